// *** design/spi_pkg.sv ***
// shared constants for the fault report serial link
package spi_pkg;
    // frame and word layout
    localparam int FRAME_BITS  = 16;
    localparam int CNT_W       = 4;
    localparam int CH_NUM      = 6;
    localparam int FAULT_W     = 12;
    localparam int TX_PAD_W    = FRAME_BITS - FAULT_W;
    localparam int CMD_DATA_W  = 6;
    localparam int CMD_ADDR_HI = 15;
    localparam int CMD_ADDR_LO = 12;
    localparam int CMD_SEL_W   = CMD_ADDR_HI - CMD_ADDR_LO + 1;
    localparam int NUM_CFG     = 4;
    localparam int CFG_IDX_W   = 2;

    localparam logic [CNT_W-1:0]     CNT_LAST   = 4'hF;
    localparam logic [TX_PAD_W-1:0]  TX_PAD     = 4'h0;
    localparam logic [CFG_IDX_W-1:0] CFG_GATE   = 2'h0;
    localparam logic [CMD_SEL_W-1:0] CFG_SEL_LIM = 4'h4;

    // host side request widths
    localparam int HOST_DATA_W = 32;
    localparam int HOST_LEN_W  = 6;
    localparam int TMR_W       = 8;

    // timing, core clock 200 MHz
    localparam int  CORE_PERIOD_NS  = 5;
    localparam int  SCLK_HALF_NS    = 125;
    localparam int  CS_HOLD_NS      = 75;
    localparam real TRANSFER_GAP_US = 1.0;

    localparam int HALF_CYC = SCLK_HALF_NS / CORE_PERIOD_NS;
    localparam int HOLD_CYC = (CS_HOLD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int GAP_CYC  = int'($ceil(TRANSFER_GAP_US * 1000.0 / CORE_PERIOD_NS));

    localparam logic [TMR_W-1:0] HALF_TICKS = TMR_W'(HALF_CYC - 1);
    localparam logic [TMR_W-1:0] HOLD_TICKS = TMR_W'(HOLD_CYC - 1);
    localparam logic [TMR_W-1:0] GAP_TICKS  = TMR_W'(GAP_CYC - 1);
    localparam logic [TMR_W-1:0] TMR_ZERO   = 8'h00;
    localparam logic [HOST_LEN_W-1:0] LEN_ZERO = 6'h00;

    // host sequencer states
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOW  = 3'b001,
        H_HIGH = 3'b010,
        H_HOLD = 3'b011,
        H_GAP  = 3'b100
    } host_state_e;
endpackage : spi_pkg

// *** design/spi_link_if.sv ***
// serial link wires between host and fault report slave
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
    logic chip_select_n;
    logic sclk;
    logic si;
    logic so_o;
    logic so_oe;
    logic so;

    // released line reads low
    assign so = so_oe ? so_o : 1'b0;

    modport device (input chip_select_n, input sclk, input si, output so_o, output so_oe);
    modport host   (output chip_select_n, output sclk, output si, input so);
endinterface : spi_link_if
`default_nettype wire

// *** design/spi_link_host.sv ***
// host end: frames words onto the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_link_host
    import spi_pkg::*;
(
    // clock and reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST_B,
    input  wire logic                   CLK_EN,
    // request
    input  wire logic                   REQ_VALID,
    input  wire logic [HOST_DATA_W-1:0] REQ_DATA,
    input  wire logic [HOST_LEN_W-1:0]  REQ_BITS,
    output logic                        REQ_READY,
    // answer
    output logic                        RSP_VALID,
    output logic [HOST_DATA_W-1:0]      RSP_DATA,
    // link
    spi_link_if.host                    LINK
);
    import spi_pkg::*;

    typedef struct packed {
        host_state_e            st;
        logic [TMR_W-1:0]       tmr;
        logic [HOST_LEN_W-1:0]  left;
        logic [HOST_DATA_W-1:0] tx;
        logic [HOST_DATA_W-1:0] rx;
        logic                   cs_n;
        logic                   sclk;
        logic                   si;
        logic                   so_s1;
        logic                   so_s2;
        logic                   ready;
        logic                   rsp_valid;
    } host_s;

    host_s r_reg;
    host_s r_next;

    always_comb begin
        r_next           = r_reg;
        r_next.rsp_valid = 1'b0;
        r_next.so_s1     = LINK.so;
        r_next.so_s2     = r_reg.so_s1;
        case (r_reg.st)
            H_IDLE: begin
                if (REQ_VALID && r_reg.ready && REQ_BITS != LEN_ZERO) begin
                    r_next.ready = 1'b0;
                    r_next.cs_n  = 1'b0;
                    r_next.tx    = REQ_DATA;
                    r_next.si    = REQ_DATA[HOST_DATA_W-1];
                    r_next.left  = REQ_BITS;
                    r_next.rx    = '0;
                    r_next.tmr   = HALF_TICKS;
                    r_next.st    = H_LOW;
                end
            end
            H_LOW: begin
                if (r_reg.tmr == TMR_ZERO) begin
                    r_next.sclk = 1'b1;
                    r_next.rx   = {r_reg.rx[HOST_DATA_W-2:0], r_reg.so_s2};
                    r_next.left = r_reg.left - 1'b1;
                    r_next.tmr  = HALF_TICKS;
                    r_next.st   = H_HIGH;
                end else begin
                    r_next.tmr = r_reg.tmr - 1'b1;
                end
            end
            H_HIGH: begin
                if (r_reg.tmr == TMR_ZERO) begin
                    r_next.sclk = 1'b0;
                    if (r_reg.left == LEN_ZERO) begin
                        r_next.tmr = HOLD_TICKS;
                        r_next.st  = H_HOLD;
                    end else begin
                        r_next.tx  = {r_reg.tx[HOST_DATA_W-2:0], 1'b0};
                        r_next.si  = r_reg.tx[HOST_DATA_W-2];
                        r_next.tmr = HALF_TICKS;
                        r_next.st  = H_LOW;
                    end
                end else begin
                    r_next.tmr = r_reg.tmr - 1'b1;
                end
            end
            H_HOLD: begin
                if (r_reg.tmr == TMR_ZERO) begin
                    r_next.cs_n      = 1'b1;
                    r_next.rsp_valid = 1'b1;
                    r_next.tmr       = GAP_TICKS;
                    r_next.st        = H_GAP;
                end else begin
                    r_next.tmr = r_reg.tmr - 1'b1;
                end
            end
            H_GAP: begin
                if (r_reg.tmr == TMR_ZERO) begin
                    r_next.ready = 1'b1;
                    r_next.st    = H_IDLE;
                end else begin
                    r_next.tmr = r_reg.tmr - 1'b1;
                end
            end
            default: begin
                r_next.st   = H_IDLE;
                r_next.cs_n = 1'b1;
                r_next.sclk = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            r_reg       <= '0;
            r_reg.cs_n  <= 1'b1;
            r_reg.ready <= 1'b1;
        end else if (CLK_EN) begin
            r_reg <= r_next;
        end
    end

    assign REQ_READY          = r_reg.ready;
    assign RSP_VALID          = r_reg.rsp_valid;
    assign RSP_DATA           = r_reg.rx;
    assign LINK.chip_select_n = r_reg.cs_n;
    assign LINK.sclk          = r_reg.sclk;
    assign LINK.si            = r_reg.si;
endmodule : spi_link_host
`default_nettype wire

// *** design/fault_report_spi_slave.sv ***
// device end: fault report serial slave with frame checking
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - valid frame needs multiple of 16 rising clocks
// - frame error sets fault flag from present faults
// - full duplex, msb first, on host clock
// - serial output changes on falling clock edges
// - serial input sampled on rising clock edges
// - select fall: reset count, load faults, clear flag
// - faults during frame captured after select rises
// - valid frame end decodes last word, flag enabled
// - valid frame end recaptures present fault state
// - error frame: command dropped, fault data kept
// - flag follows channel faults, never frame errors
// - host keeps select high at least 1us
// - reset: gates low, defaults, flags off
// - supply good enables outputs and commands
// - supply low clears flags, forces gates low
// - host idles serial clock low
// - works alone or inside a daisy chain
// - outgoing word: four zeros, twelve fault bits
// - command: select field plus six data bits
// - host sends zero command msb
module fault_report_spi_slave
    import spi_pkg::*;
(
    // clock and reset
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST_B,
    input  wire logic                  CLK_EN,
    // serial link
    spi_link_if.device                 LINK,
    // fault and supply status
    input  wire logic [FAULT_W-1:0]    FAULT_CODE,
    input  wire logic                  STATUS_COND,
    input  wire logic                  LOGIC_SUPPLY_OK,
    // gate drive
    output logic [CH_NUM-1:0]          GATE_DRIVE_OUT,
    // open-drain flags
    output logic                       FAULT_FLAG_N_O,
    output logic                       FAULT_FLAG_N_OE,
    output logic                       STATUS_FLAG_N_O,
    output logic                       STATUS_FLAG_N_OE,
    // decoded command
    output logic                       CMD_STROBE,
    output logic [CFG_IDX_W-1:0]       CMD_ADDR,
    output logic [CMD_DATA_W-1:0]      CMD_DATA,
    output logic                       FRAME_ERROR
);
    import spi_pkg::*;

    typedef struct packed {
        logic                                 cs_s1;
        logic                                 cs_s2;
        logic                                 cs_d;
        logic                                 sck_s1;
        logic                                 sck_s2;
        logic                                 sck_d;
        logic                                 si_s1;
        logic                                 si_s2;
        logic                                 sup_s1;
        logic                                 sup_s2;
        logic [CNT_W-1:0]                     bit_cnt;
        logic                                 got_word;
        logic [FRAME_BITS-1:0]                rx_sr;
        logic [FRAME_BITS-1:0]                tx_sr;
        logic                                 so_bit;
        logic                                 so_en;
        logic [FAULT_W-1:0]                   fault_latch;
        logic                                 fault_set;
        logic                                 fault_oe;
        logic                                 status_oe;
        logic                                 flag_lo;
        logic [NUM_CFG-1:0][CMD_DATA_W-1:0]   cfg;
        logic [CH_NUM-1:0]                    gate;
        logic                                 cmd_strobe;
        logic [CFG_IDX_W-1:0]                 cmd_addr;
        logic [CMD_DATA_W-1:0]                cmd_data;
        logic                                 frame_err;
    } dev_s;

    dev_s r_reg;
    dev_s r_next;

    // select field must name an existing register
    function automatic logic sel_ok(input logic [CMD_SEL_W-1:0] sel);
        sel_ok = (sel < CFG_SEL_LIM);
    endfunction : sel_ok

    logic                 cs_fall;
    logic                 cs_rise;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 frame_ok;
    logic [CMD_SEL_W-1:0] cmd_sel;

    always_comb begin
        r_next            = r_reg;
        r_next.cmd_strobe = 1'b0;
        r_next.frame_err  = 1'b0;

        // two-stage synchronisers, edges from stage two onward
        r_next.cs_s1  = LINK.chip_select_n;
        r_next.cs_s2  = r_reg.cs_s1;
        r_next.cs_d   = r_reg.cs_s2;
        r_next.sck_s1 = LINK.sclk;
        r_next.sck_s2 = r_reg.sck_s1;
        r_next.sck_d  = r_reg.sck_s2;
        r_next.si_s1  = LINK.si;
        r_next.si_s2  = r_reg.si_s1;
        r_next.sup_s1 = LOGIC_SUPPLY_OK;
        r_next.sup_s2 = r_reg.sup_s1;

        cs_fall  = r_reg.cs_d & ~r_reg.cs_s2;
        cs_rise  = ~r_reg.cs_d & r_reg.cs_s2;
        sck_rise = ~r_reg.sck_d & r_reg.sck_s2 & ~r_reg.cs_s2;
        sck_fall = r_reg.sck_d & ~r_reg.sck_s2 & ~r_reg.cs_s2;
        frame_ok = r_reg.got_word && (r_reg.bit_cnt == '0);
        cmd_sel  = r_reg.rx_sr[CMD_ADDR_HI:CMD_ADDR_LO];

        // output driven only inside a frame
        r_next.so_en = ~r_reg.cs_s2 & r_reg.sup_s2;

        if (!r_reg.sup_s2) begin
            r_next.fault_set = 1'b0;
            r_next.fault_oe  = 1'b0;
            r_next.status_oe = 1'b0;
            r_next.gate      = '0;
            r_next.bit_cnt   = '0;
            r_next.got_word  = 1'b0;
        end else begin
            if (cs_fall) begin
                r_next.bit_cnt   = '0;
                r_next.got_word  = 1'b0;
                r_next.tx_sr     = {TX_PAD, r_reg.fault_latch};
                r_next.so_bit    = TX_PAD[TX_PAD_W-1];
                r_next.fault_set = 1'b0;
            end else if (sck_rise) begin
                r_next.rx_sr   = {r_reg.rx_sr[FRAME_BITS-2:0], r_reg.si_s2};
                r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
                if (r_reg.bit_cnt == CNT_LAST) begin
                    r_next.got_word = 1'b1;
                end
            end else if (sck_fall) begin
                // received bits follow the fault word out
                r_next.tx_sr  = {r_reg.tx_sr[FRAME_BITS-2:0], r_reg.rx_sr[0]};
                r_next.so_bit = r_reg.tx_sr[FRAME_BITS-2];
            end else if (cs_rise) begin
                if (frame_ok) begin
                    if (sel_ok(cmd_sel)) begin
                        r_next.cfg[cmd_sel[CFG_IDX_W-1:0]] =
                            r_reg.rx_sr[CMD_DATA_W-1:0];
                        r_next.cmd_strobe = 1'b1;
                        r_next.cmd_addr   = cmd_sel[CFG_IDX_W-1:0];
                        r_next.cmd_data   = r_reg.rx_sr[CMD_DATA_W-1:0];
                    end
                    r_next.fault_latch = FAULT_CODE;
                    r_next.fault_set   = |FAULT_CODE;
                end else begin
                    r_next.frame_err   = 1'b1;
                    r_next.fault_latch = r_reg.fault_latch | FAULT_CODE;
                    r_next.fault_set   = |FAULT_CODE;
                end
            end else if (r_reg.cs_s2) begin
                // faults only gathered between frames
                r_next.fault_latch = r_reg.fault_latch | FAULT_CODE;
                if (|FAULT_CODE) begin
                    r_next.fault_set = 1'b1;
                end
            end
            // flags never look at frame errors
            r_next.fault_oe  = r_next.fault_set & r_reg.cs_s2;
            r_next.status_oe = STATUS_COND;
            r_next.gate      = r_reg.cfg[CFG_GATE];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            r_reg        <= '0;
            r_reg.cs_s1  <= 1'b1;
            r_reg.cs_s2  <= 1'b1;
            r_reg.cs_d   <= 1'b1;
        end else if (CLK_EN) begin
            r_reg <= r_next;
        end
    end

    assign LINK.so_o        = r_reg.so_bit;
    assign LINK.so_oe       = r_reg.so_en;
    assign GATE_DRIVE_OUT   = r_reg.gate;
    assign FAULT_FLAG_N_O   = r_reg.flag_lo;
    assign FAULT_FLAG_N_OE  = r_reg.fault_oe;
    assign STATUS_FLAG_N_O  = r_reg.flag_lo;
    assign STATUS_FLAG_N_OE = r_reg.status_oe;
    assign CMD_STROBE       = r_reg.cmd_strobe;
    assign CMD_ADDR         = r_reg.cmd_addr;
    assign CMD_DATA         = r_reg.cmd_data;
    assign FRAME_ERROR      = r_reg.frame_err;
endmodule : fault_report_spi_slave
`default_nettype wire

// *** tb/fault_link_props.sv ***
// checker for the serial link between host and fault report slave
`timescale 1ns/1ps
`default_nettype none
module fault_link_props
    import spi_pkg::*;
(
    // clock and reset
    input  wire logic CORE_CLK,
    input  wire logic RST_B,
    // link wires
    input  wire logic chip_select_n,
    input  wire logic sclk,
    input  wire logic so_o,
    input  wire logic so_oe,
    // device results
    input  wire logic FAULT_FLAG_N_OE,
    input  wire logic CMD_STROBE,
    input  wire logic FRAME_ERROR
);
    logic [7:0] hi_cnt_reg;
    logic [7:0] edge_cnt_reg;
    logic       sclk_d_reg;
    logic       cs_d_reg;

    // select high time and rising clocks within a frame
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hi_cnt_reg   <= 8'hFF;
            edge_cnt_reg <= 8'h00;
            sclk_d_reg   <= 1'b0;
            cs_d_reg     <= 1'b1;
        end else begin
            sclk_d_reg <= sclk;
            cs_d_reg   <= chip_select_n;
            if (!chip_select_n) begin
                hi_cnt_reg <= 8'h00;
            end else if (hi_cnt_reg != 8'hFF) begin
                hi_cnt_reg <= hi_cnt_reg + 8'h01;
            end
            if (!chip_select_n && cs_d_reg) begin
                edge_cnt_reg <= 8'h00;
            end else if (!chip_select_n && sclk && !sclk_d_reg) begin
                edge_cnt_reg <= edge_cnt_reg + 8'h01;
            end
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    sequence s_start;
        $fell(chip_select_n);
    endsequence
    sequence s_end;
        $rose(chip_select_n);
    endsequence

    chk_load_word: assert property (s_start |-> ##[2:6] (so_oe && !so_o))
        else $error("serial output not loaded after select fall");
    chk_out_release: assert property (s_end |-> ##[1:6] !so_oe)
        else $error("serial output not released after select rise");
    chk_out_fall: assert property ((so_oe && $past(so_oe) && so_o != $past(so_o))
        |-> (!sclk && !$past(sclk, 2)))
        else $error("serial output changed outside clock low phase");
    chk_out_steady: assert property ($rose(sclk) |=> $stable(so_o) [*8])
        else $error("serial output moved around rising clock");
    chk_flag_off: assert property (!chip_select_n [*6] |-> !FAULT_FLAG_N_OE)
        else $error("fault flag active inside frame");
    chk_end_timing: assert property ((CMD_STROBE || FRAME_ERROR)
        |-> (chip_select_n && hi_cnt_reg inside {[1:8]}))
        else $error("frame result not right after select rise");
    chk_count_valid: assert property (CMD_STROBE
        |-> (edge_cnt_reg[3:0] == 4'h0 && edge_cnt_reg != 8'h00))
        else $error("command taken from bad clock count");
    chk_count_error: assert property (FRAME_ERROR
        |-> (edge_cnt_reg[3:0] != 4'h0 || edge_cnt_reg == 8'h00))
        else $error("frame error on whole word count");
    chk_err_no_cmd: assert property (FRAME_ERROR |-> !CMD_STROBE)
        else $error("command accepted on frame error");
    chk_select_gap: assert property (s_start |-> hi_cnt_reg >= GAP_CYC)
        else $error("select high gap too short");
    chk_sclk_idle: assert property (chip_select_n |-> !sclk)
        else $error("serial clock high between frames");
endmodule : fault_link_props
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: host and fault report slave on one link, checked against a model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spi_pkg::*;
    logic                   clk, rst_b, req_valid, req_ready, rsp_valid;
    logic [HOST_DATA_W-1:0] req_data, rsp_data, d;
    logic [HOST_LEN_W-1:0]  req_bits;
    logic [FAULT_W-1:0]     fault_code, latch, f;
    logic                   status_cond, supply_ok, ff_oe, sf_oe, strobe, frame_err, ff_o, sf_o;
    logic [CH_NUM-1:0]      gate, cfg0;
    logic [CFG_IDX_W-1:0]   cmd_addr;
    logic [CMD_DATA_W-1:0]  cmd_data;
    int                     mismatches = 0, checked = 0, n_strobe = 0, n_err = 0;
    int                     seed = 32'h61f6, k, nb, sel_n = 0;
    int                     lens [12] = '{16, 32, 8, 24, 16, 32, 12, 16, 4, 32, 16, 16};

    spi_link_if spi_link_if_inst ();
    spi_link_host spi_link_host_inst (.CORE_CLK(clk), .RST_B(rst_b), .CLK_EN(1'b1),
        .REQ_VALID(req_valid), .REQ_DATA(req_data), .REQ_BITS(req_bits),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .LINK(spi_link_if_inst.host));
    fault_report_spi_slave fault_report_spi_slave_inst (.CORE_CLK(clk), .RST_B(rst_b),
        .CLK_EN(1'b1), .LINK(spi_link_if_inst.device), .FAULT_CODE(fault_code),
        .STATUS_COND(status_cond), .LOGIC_SUPPLY_OK(supply_ok), .GATE_DRIVE_OUT(gate),
        .FAULT_FLAG_N_O(ff_o), .FAULT_FLAG_N_OE(ff_oe), .STATUS_FLAG_N_O(sf_o),
        .STATUS_FLAG_N_OE(sf_oe), .CMD_STROBE(strobe), .CMD_ADDR(cmd_addr),
        .CMD_DATA(cmd_data), .FRAME_ERROR(frame_err));
    fault_link_props fault_link_props_inst (.CORE_CLK(clk), .RST_B(rst_b),
        .chip_select_n(spi_link_if_inst.chip_select_n), .sclk(spi_link_if_inst.sclk),
        .so_o(spi_link_if_inst.so_o), .so_oe(spi_link_if_inst.so_oe),
        .FAULT_FLAG_N_OE(ff_oe), .CMD_STROBE(strobe), .FRAME_ERROR(frame_err));

    // count result strobes
    always @(posedge clk) begin
        if (strobe === 1'b1) n_strobe++;
        if (frame_err === 1'b1) n_err++;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic give_up();
        mismatches++;
        test_done();
    endtask : give_up

    // one host frame; fault code changes while select is low
    task automatic frame(input int n, input logic [31:0] dv, input logic [11:0] fv);
        logic [31:0] exp_rsp;
        logic [31:0] mask;
        logic [15:0] outw;
        logic [15:0] cmd;
        int          i, s0, e0;
        outw = {4'h0, latch};
        exp_rsp = 32'h0;
        for (i = 0; i < n; i++) exp_rsp = {exp_rsp[30:0], (i < 16) ? outw[15-i] : dv[31-(i%16)]};
        mask = (n == 32) ? 32'hFFFF_FFFF : ((32'h1 << n) - 32'h1);
        cmd = 16'(dv >> (32 - n));
        s0 = n_strobe;
        e0 = n_err;
        for (i = 0; i < 1000 && req_ready !== 1'b1; i++) @(posedge clk);
        if (req_ready !== 1'b1) give_up();
        req_valid <= 1'b1;
        req_data <= dv;
        req_bits <= 6'(n);
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (20) @(posedge clk);
        fault_code <= fv;
        status_cond <= 1'($random(seed));
        for (i = 0; i < 4000 && rsp_valid !== 1'b1; i++) @(posedge clk);
        if (rsp_valid !== 1'b1) give_up();
        repeat (12) @(posedge clk);
        check("reply", rsp_data & mask, exp_rsp);
        if (n % 16 == 0) begin
            latch = fv;
            if (cmd[15:12] < 4'h4) begin
                check("strobes", n_strobe - s0, 32'h1);
                check("command", {cmd_addr, cmd_data}, {cmd[13:12], cmd[5:0]});
                if (cmd[13:12] == 2'h0) cfg0 = cmd[5:0];
            end else begin
                check("strobes", n_strobe - s0, 32'h0);
            end
            check("errors", n_err - e0, 32'h0);
        end else begin
            latch = latch | fv;
            check("errors", n_err - e0, 32'h1);
            check("strobes", n_strobe - s0, 32'h0);
        end
        check("fault flag", {ff_oe, ff_o}, {fv != 12'h000, 1'b0});
        check("status flag", {sf_oe, sf_o}, {status_cond, 1'b0});
        check("gates", gate, cfg0);
    endtask : frame

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_data = 32'h0;
        req_bits = 6'h00;
        fault_code = 12'h000;
        status_cond = 1'b0;
        supply_ok = 1'b1;
        latch = 12'h000;
        cfg0 = 6'h00;
        repeat (10) @(posedge clk);
        check("reset outputs", {gate, ff_oe, sf_oe, spi_link_if_inst.so_oe}, 32'h0);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        for (k = 0; k < 12; k++) begin
            nb = lens[k];
            d = $random(seed);
            if (nb % 16 == 0) begin
                d[47 - nb -: 4] = 4'(sel_n % 6);
                sel_n++;
            end
            f = (k % 4 == 3) ? 12'h000 : 12'($random(seed));
            frame(nb, d, f);
        end
        supply_ok <= 1'b0;
        repeat (8) @(posedge clk);
        check("supply low", {gate, ff_oe, sf_oe}, 32'h0);
        supply_ok <= 1'b1;
        status_cond <= 1'b1;
        repeat (8) @(posedge clk);
        check("supply back", {gate, sf_oe}, {cfg0, 1'b1});
        test_done();
    end
endmodule : testbench
`default_nettype wire
